//--- rtl/nei_defs.svh
`ifndef NEI_DEFS_SVH
`define NEI_DEFS_SVH

// ==========================================================
// Register map (byte addresses, one 32-bit word each)
`define NEI_ADDR_CTRL      12'h000
`define NEI_ADDR_STATUS    12'h004
`define NEI_ADDR_IGNCNT    12'h008
`define NEI_ADDR_HALTCNT   12'h00c

// ==========================================================
// Control register fields
`define NEI_CTRL_MODE_BIT  0
`define NEI_CTRL_DUAL_BIT  1
`define NEI_CTRL_MODE_RST  1'b0
`define NEI_CTRL_DUAL_RST  1'b0

// ==========================================================
// Status register fields
`define NEI_ST_IGN_PIN_BIT 0
`define NEI_ST_IGN_EFF_BIT 1
`define NEI_ST_ERRSUM_BIT  2
`define NEI_ST_HALT_BIT    3
`define NEI_ST_BIST_BIT    4
`define NEI_ST_BISTRAN_BIT 5

// ==========================================================
// Timing counts in clk cycles
`define NEI_BOOT_CYCLES    8'h02
`define NEI_BIST_CYCLES    8'h40

// ==========================================================
// Floating-point instruction codes on fp_insn_op
`define NEI_OP_INIT        4'h0
`define NEI_OP_CLEX        4'h1
`define NEI_OP_STENV       4'h2
`define NEI_OP_SAVE        4'h3
`define NEI_OP_STSW        4'h4
`define NEI_OP_STCW        4'h5
`define NEI_OP_LEG_ENI     4'h6
`define NEI_OP_LEG_DISI    4'h7
`define NEI_OP_LEG_SETPM   4'h8
`define NEI_OP_LAST_CTRL   4'h8

`endif

//--- rtl/nei_pkg.sv
`default_nettype none

package nei_pkg;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_BIST,
    ST_RUN,
    ST_HALT,
    ST_INIT
  } nei_state_t;

  typedef logic [3:0] nei_op_t;

endpackage

`default_nettype wire

//--- rtl/nei_sync.sv
`default_nettype none

module nei_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic d,
  output var  logic q
);

  logic meta_reg;

  // ==========================================================
  // Two-flop chain; only the second flop is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

//--- rtl/nei_ctrl.sv
// What this block does
// (RQ1) Native error mode set: ignore pin has no effect
// (RQ2) Ignore asserted: skip pending exception, keep executing
// (RQ3) Control-class instructions run despite pending exception; with native error mode set they fault instead
// (RQ4) Other instructions halt until external interrupt
// (RQ5) Secondary dual-processor role masks ignore pin
// (RQ6) Soft init restarts like reset, keeps caches
// (RQ7) System must apply hardware reset after power-up
// (RQ8) Soft init high at reset release runs self test
// (RQ9) Pins synchronised; ignore checked per instruction
`include "nei_defs.svh"
`default_nettype none

module nei_ctrl
  import nei_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // Pins from system logic
  input  wire logic        ignore_numeric_error_n,
  input  wire logic        soft_init,
  input  wire logic        external_interrupt,
  // Core side
  input  wire logic        fp_insn_valid,
  input  wire logic [3:0]  fp_insn_op,
  input  wire logic        fpu_error_summary_flag,
  output var  logic        fp_insn_ready,
  output var  logic        fp_insn_exec,
  output var  logic        fp_insn_ignored,
  output var  logic        fp_insn_fault,
  output var  logic        core_halted,
  output var  logic        core_restart,
  output var  logic        bist_active
);

  // ==========================================================
  // Declarations
  nei_state_t  state_reg;
  nei_state_t  state_next;
  logic [7:0]  cnt_reg;
  logic        ign_sync_n;
  logic        init_sync;
  logic        intr_sync;
  logic        init_prev_reg;
  logic        init_rise;
  logic        native_error_mode_bit;
  logic        dual_secondary_reg;
  logic        bist_ran_reg;
  logic [15:0] ign_cnt_reg;
  logic [15:0] halt_cnt_reg;
  logic        ign_eff;
  logic        is_ctrl_op;
  logic        take;
  logic        out_exec;
  logic        out_ignored;
  logic        out_fault;
  logic        out_halt;
  logic        apb_access;
  logic        apb_wr;
  logic [31:0] rd_next;
  logic        err_next;

  // ==========================================================
  // Pin synchronisers
  nei_sync #(.RESET_VAL(1'b1)) u_sync_ign (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ignore_numeric_error_n),
    .q     (ign_sync_n)
  ); // [RQ9]

  nei_sync #(.RESET_VAL(1'b0)) u_sync_init (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (soft_init),
    .q     (init_sync)
  ); // [RQ9]

  nei_sync #(.RESET_VAL(1'b0)) u_sync_intr (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (external_interrupt),
    .q     (intr_sync)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_prev_reg <= 1'b0;
    end else begin
      init_prev_reg <= init_sync;
    end
  end

  // Level held through boot is a strap, not a restart request
  assign init_rise = init_sync && !init_prev_reg && (state_reg != ST_BOOT);

  // ==========================================================
  // Exception decision at each instruction boundary
  assign ign_eff    = !native_error_mode_bit && !dual_secondary_reg && !ign_sync_n; // [RQ1] [RQ5]
  assign is_ctrl_op = (fp_insn_op <= `NEI_OP_LAST_CTRL); // [RQ3]
  assign take       = fp_insn_valid && (state_reg == ST_RUN) && !init_rise; // [RQ9]

  always_comb begin
    out_exec    = 1'b0;
    out_ignored = 1'b0;
    out_fault   = 1'b0;
    out_halt    = 1'b0;
    if (take) begin
      if (!fpu_error_summary_flag) begin
        out_exec = 1'b1;
      end else if (native_error_mode_bit) begin
        out_fault = 1'b1; // [RQ1]
      end else if (ign_eff) begin
        out_exec    = 1'b1; // [RQ2]
        out_ignored = 1'b1;
      end else if (is_ctrl_op) begin
        out_exec = 1'b1; // [RQ3]
      end else begin
        out_halt = 1'b1; // [RQ4]
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: begin
        // Strap sampled once synchronisers hold post-reset values
        if (cnt_reg == `NEI_BOOT_CYCLES) begin
          state_next = init_sync ? ST_BIST : ST_RUN; // [RQ8] [RQ7]
        end
      end
      ST_BIST: begin
        if (cnt_reg == `NEI_BIST_CYCLES) begin
          state_next = ST_RUN; // [RQ8]
        end
      end
      ST_RUN: begin
        if (init_rise) begin
          state_next = ST_INIT; // [RQ6]
        end else if (out_halt) begin
          state_next = ST_HALT; // [RQ4]
        end
      end
      ST_HALT: begin
        if (init_rise) begin
          state_next = ST_INIT; // [RQ6]
        end else if (intr_sync) begin
          state_next = ST_RUN; // [RQ4]
        end
      end
      ST_INIT: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (state_next != state_reg) begin
      cnt_reg <= 8'h00;
    end else if (state_reg == ST_BOOT || state_reg == ST_BIST) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bist_ran_reg <= 1'b0;
    end else if (state_reg == ST_BIST) begin
      bist_ran_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Core-side outputs, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_insn_ready   <= 1'b0;
      fp_insn_exec    <= 1'b0;
      fp_insn_ignored <= 1'b0;
      fp_insn_fault   <= 1'b0;
      core_halted     <= 1'b0;
      core_restart    <= 1'b0;
      bist_active     <= 1'b0;
    end else begin
      fp_insn_ready   <= (state_next == ST_RUN);
      fp_insn_exec    <= out_exec;
      fp_insn_ignored <= out_ignored; // [RQ2]
      fp_insn_fault   <= out_fault;
      core_halted     <= (state_next == ST_HALT); // [RQ4]
      core_restart    <= (state_next == ST_INIT); // [RQ6]
      bist_active     <= (state_next == ST_BIST); // [RQ8]
    end
  end

  // ==========================================================
  // Event counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ign_cnt_reg  <= 16'h0000;
      halt_cnt_reg <= 16'h0000;
    end else begin
      if (out_ignored) begin
        ign_cnt_reg <= ign_cnt_reg + 16'h0001;
      end
      if (out_halt) begin
        halt_cnt_reg <= halt_cnt_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // APB slave: one wait state, so pready and prdata come from flops
  assign apb_access = psel && penable && !pready;
  assign apb_wr     = psel && penable && pready && pwrite;

  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == `NEI_ADDR_CTRL) begin
      rd_next[`NEI_CTRL_MODE_BIT] = native_error_mode_bit;
      rd_next[`NEI_CTRL_DUAL_BIT] = dual_secondary_reg;
    end else if (paddr == `NEI_ADDR_STATUS) begin
      rd_next[`NEI_ST_IGN_PIN_BIT] = !ign_sync_n;
      rd_next[`NEI_ST_IGN_EFF_BIT] = ign_eff;
      rd_next[`NEI_ST_ERRSUM_BIT]  = fpu_error_summary_flag;
      rd_next[`NEI_ST_HALT_BIT]    = (state_reg == ST_HALT);
      rd_next[`NEI_ST_BIST_BIT]    = (state_reg == ST_BIST);
      rd_next[`NEI_ST_BISTRAN_BIT] = bist_ran_reg;
    end else if (paddr == `NEI_ADDR_IGNCNT) begin
      rd_next[15:0] = ign_cnt_reg;
    end else if (paddr == `NEI_ADDR_HALTCNT) begin
      rd_next[15:0] = halt_cnt_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access;
      prdata  <= (apb_access && !pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= apb_access && err_next;
    end
  end

  // Soft init clears the mode bit like reset; role bit is configuration and stays
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      native_error_mode_bit <= `NEI_CTRL_MODE_RST;
      dual_secondary_reg    <= `NEI_CTRL_DUAL_RST;
    end else if (state_next == ST_INIT && state_reg != ST_INIT) begin
      native_error_mode_bit <= `NEI_CTRL_MODE_RST; // [RQ6]
    end else if (apb_wr && paddr == `NEI_ADDR_CTRL) begin
      native_error_mode_bit <= pwdata[`NEI_CTRL_MODE_BIT];
      dual_secondary_reg    <= pwdata[`NEI_CTRL_DUAL_BIT];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_native_pin_ignored: assert property ( // [RQ1]
    take && fpu_error_summary_flag && native_error_mode_bit
      |=> fp_insn_fault && !fp_insn_exec && !core_halted
  ) else $error("native mode did not report the exception");

  a_ignore_runs: assert property ( // [RQ2]
    take && fpu_error_summary_flag && !native_error_mode_bit && !dual_secondary_reg && !ign_sync_n
      |=> fp_insn_exec && fp_insn_ignored ##1 fp_insn_ready
  ) else $error("ignored exception did not let execution continue");

  a_ctrl_op_runs: assert property ( // [RQ3]
    take && fpu_error_summary_flag && !native_error_mode_bit && !ign_eff && is_ctrl_op
      |=> fp_insn_exec && !core_halted
  ) else $error("control instruction blocked by pending exception");

  a_halt_entry: assert property ( // [RQ4]
    take && fpu_error_summary_flag && !native_error_mode_bit && !ign_eff && !is_ctrl_op
      |=> core_halted && !fp_insn_exec && !fp_insn_ready
  ) else $error("pending exception did not halt");

  a_halt_holds: assert property ( // [RQ4]
    core_halted && !intr_sync && !init_rise |=> core_halted
  ) else $error("halt left without interrupt or init");

  a_dual_masks: assert property ( // [RQ5]
    take && fpu_error_summary_flag && dual_secondary_reg && !native_error_mode_bit && !is_ctrl_op
      |=> !fp_insn_exec && core_halted
  ) else $error("ignore pin acted in secondary role");

  a_init_restart: assert property ( // [RQ6]
    init_rise && (state_reg == ST_RUN || state_reg == ST_HALT)
      |=> core_restart && !native_error_mode_bit ##1 !core_restart && fp_insn_ready
  ) else $error("soft init did not restart the core");

  a_bist_length: assert property ( // [RQ8]
    $fell(bist_active) |-> $past(cnt_reg) == `NEI_BIST_CYCLES && fp_insn_ready && bist_ran_reg
  ) else $error("self test ended at wrong count");

  a_ign_sync_delay: assert property ( // [RQ9]
    state_reg != ST_BOOT |-> ign_sync_n == $past(ignore_numeric_error_n, 2)
  ) else $error("ignore pin not two flops deep");

  c_halt_wake: cover property (core_halted ##1 !core_halted && fp_insn_ready);
  c_ignored:   cover property (fp_insn_ignored);
  c_bist:      cover property ($fell(bist_active));
  c_restart:   cover property (core_restart);

endmodule

`default_nettype wire

//--- tb/nei_sys_model.sv
`default_nettype none

module nei_sys_model (
  // Clock
  input  wire logic clk,
  // Core state seen by system logic
  input  wire logic core_halted,
  // Pins driven into the device
  output var  logic ignore_numeric_error_n,
  output var  logic soft_init,
  output var  logic external_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pin drivers
  // Strap high from time zero so the level is already settled when reset releases
  initial begin
    ignore_numeric_error_n = 1'b1;
    soft_init = 1'b1;
    external_interrupt = 1'b0;
  end

  // Hardware reset comes from the bench; soft init is never used in its place
  task automatic set_ign(input logic asserted);
    @(posedge clk);
    ignore_numeric_error_n <= ~asserted;
    repeat (4) @(posedge clk);
  endtask

  task automatic set_init(input logic v);
    @(posedge clk);
    soft_init <= v;
  endtask

  // Slow answers are allowed: the interrupt may come late after the halt
  task automatic wake(input int delay, output logic ok);
    int i;
    repeat (delay) @(posedge clk);
    external_interrupt <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (core_halted !== 1'b0 && i < 20);
    external_interrupt <= 1'b0;
    ok = (i < 20);
  endtask
endmodule

`default_nettype wire

//--- tb/nei_ctrl_tb.sv
`include "nei_defs.svh"
`default_nettype none

module nei_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic        clk;
  logic        rst_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ign_n, sinit, intr;
  logic        fp_insn_valid, fpu_error_summary_flag;
  logic [3:0]  fp_insn_op;
  logic        rdy, exec, ignd, fault, halted, restart, bist;
  int          mismatches;
  int          n_compared;
  logic [31:0] r;
  logic        e;

  nei_ctrl uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ignore_numeric_error_n(ign_n), .soft_init(sinit), .external_interrupt(intr),
    .fp_insn_valid(fp_insn_valid), .fp_insn_op(fp_insn_op),
    .fpu_error_summary_flag(fpu_error_summary_flag), .fp_insn_ready(rdy),
    .fp_insn_exec(exec), .fp_insn_ignored(ignd), .fp_insn_fault(fault),
    .core_halted(halted), .core_restart(restart), .bist_active(bist));

  nei_sys_model u_sys (
    .clk(clk), .core_halted(halted), .ignore_numeric_error_n(ign_n),
    .soft_init(sinit), .external_interrupt(intr));

  always #25 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hung;
    mismatches++;
    stop_test();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hung();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits at rising edges for ready (0), self test (1) or restart (2);
  // the caller drives at the edge where the level was seen
  task automatic wait_sig(input int which, input int bound);
    int i;
    logic s;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      s = (which == 0) ? rdy : ((which == 1) ? bist : restart);
    end while (s !== 1'b1 && i < bound);
    if (i >= bound) hung();
  endtask

  // Expected answer packed as {exec, ignored, fault, halted}
  task automatic fp(input logic [3:0] op, input logic flag, input logic [3:0] exp);
    wait_sig(0, 100);
    fp_insn_valid <= 1'b1; fp_insn_op <= op; fpu_error_summary_flag <= flag;
    @(posedge clk);
    fp_insn_valid <= 1'b0;
    @(negedge clk);
    chk({28'h0, exec, ignd, fault, halted}, {28'h0, exp});
  endtask

  task automatic wake_up;
    logic ok;
    u_sys.wake(3, ok);
    if (!ok) hung();
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_bist;
    wait_sig(1, 10);
    chk(bist, 1'b1);
    u_sys.set_init(1'b0);
    wait_sig(0, 100);
    apb(1'b0, `NEI_ADDR_STATUS, 32'h0);
    chk(r & 32'h20, 32'h20);
  endtask

  task automatic sc_regs;
    apb(1'b1, `NEI_ADDR_CTRL, 32'h1);
    apb(1'b0, `NEI_ADDR_CTRL, 32'h0);
    chk({e, r[30:0]}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
  endtask

  task automatic sc_native;
    u_sys.set_ign(1'b1);
    fp(4'h9, 1'b1, 4'b0010);
  endtask

  task automatic sc_ignore;
    apb(1'b1, `NEI_ADDR_CTRL, 32'h0);
    fp(4'h9, 1'b1, 4'b1100);
    fp(4'hf, 1'b1, 4'b1100);
    apb(1'b1, `NEI_ADDR_CTRL, 32'h2);
    fp(4'h9, 1'b1, 4'b0001);
    wake_up();
    chk(halted, 1'b0);
  endtask

  task automatic sc_ctrl_ops;
    apb(1'b1, `NEI_ADDR_CTRL, 32'h0);
    u_sys.set_ign(1'b0);
    for (int op = 0; op <= 8; op++) begin
      fp(op[3:0], 1'b1, 4'b1000);
    end
    fp(4'hf, 1'b1, 4'b0001);
    chk(rdy, 1'b0);
    apb(1'b0, `NEI_ADDR_STATUS, 32'h0);
    chk(r, 32'h0000002c);
    wake_up();
    fp(4'h9, 1'b0, 4'b1000);
  endtask

  task automatic sc_init;
    apb(1'b1, `NEI_ADDR_CTRL, 32'h3);
    u_sys.set_init(1'b1);
    wait_sig(2, 10);
    chk(restart, 1'b1);
    u_sys.set_init(1'b0);
    wait_sig(0, 10);
    apb(1'b0, `NEI_ADDR_CTRL, 32'h0);
    chk(r, 32'h2);
    // Counters survive soft init: two ignored exceptions, two halts so far
    apb(1'b0, `NEI_ADDR_IGNCNT, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, `NEI_ADDR_HALTCNT, 32'h0);
    chk(r, 32'h2);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; fp_insn_valid = 1'b0; fp_insn_op = 4'h0;
    fpu_error_summary_flag = 1'b0; mismatches = 0; n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    sc_bist();
    sc_regs();
    sc_native();
    sc_ignore();
    sc_ctrl_ops();
    sc_init();
    stop_test();
  end
endmodule

`default_nettype wire
